// *** common/iog_cfg.svh ***
// Purpose: offsets, field positions, reset values and counts of the I/O glue block
// Assumes: 8-bit I/O page, full decode of A7-A0
// Notes: definitions only
`ifndef IOG_CFG_SVH
`define IOG_CFG_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define IOG_ADDR_P1_DIR 8'hE0
`define IOG_ADDR_P1_DATA 8'hE1
`define IOG_ADDR_P2_DIR 8'hE2
`define IOG_ADDR_P2_DATA 8'hE3
`define IOG_ADDR_TMR_BASE 8'hE4
`define IOG_ADDR_SER_CTRL 8'hE8
`define IOG_ADDR_SER_DATA 8'hE9
`define IOG_ADDR_RAM_UB 8'hEA
`define IOG_ADDR_RAM_LB 8'hEB
`define IOG_ADDR_ROM_UB 8'hEC
`define IOG_ADDR_SYS_CFG 8'hED
`define IOG_ADDR_RSVD0 8'hEE
`define IOG_ADDR_RSVD1 8'hEF
`define IOG_PAGE_HI 4'hE

// ----------------------------------------
// system_config fields
// ----------------------------------------
`define IOG_CFG_TMR_BIT 0
`define IOG_CFG_EMU_BIT 1
`define IOG_CFG_ROMDIS_BIT 5

// ----------------------------------------
// reset values
// ----------------------------------------
`define IOG_RST_DIR 8'h00
`define IOG_RST_DATA 8'h00
`define IOG_RST_RAM_UB 8'hFF
`define IOG_RST_RAM_LB 8'h80
`define IOG_RST_ROM_UB 8'h7F
`define IOG_RST_CFG 8'h00

// ----------------------------------------
// counts
// ----------------------------------------
`define IOG_SER_WAIT_STATES 2'h2

`endif

// *** common/iog_pkg.sv ***
// Purpose: shared types of the I/O glue block
// Assumes: core I/O bus with one-cycle read and write strobes
// Notes: constants live in iog_cfg.svh
package iog_pkg;

    // ----------------------------------------
    // core I/O request
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic rd;
        logic wr;
    } iog_io_req_t;

    // ----------------------------------------
    // pin drive of one 8-bit port
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } iog_pin_drv_t;

endpackage : iog_pkg

// *** design/iog_port.sv ***
// Purpose: one 8-bit parallel port with data and direction registers
// Assumes: direction bit 1 = output
// Notes: data reads return pin level on input bits
`timescale 1ns/1ps
`include "iog_cfg.svh"

module iog_port (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic wr_dir,
    input wire logic wr_data,
    input wire logic [7:0] wdata,
    input wire logic [7:0] pin_in,
    output logic [7:0] dir,
    output logic [7:0] data_rd,
    output iog_pkg::iog_pin_drv_t drv
);
    logic [7:0] data;

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            dir <= `IOG_RST_DIR;
            data <= `IOG_RST_DATA;
        end else begin
            if (wr_dir) dir <= wdata;
            if (wr_data) data <= wdata;
        end
    end

    assign drv.out = data;
    assign drv.oe = dir;
    assign data_rd = (dir & data) | (~dir & pin_in);

    a_dir_write: assert property (@(posedge core_clk) disable iff (!rstn)
        wr_dir |=> drv.oe == $past(wdata))
        else $error("direction write not applied to pin enables");

endmodule : iog_port

// *** design/iog_csel.sv ***
// Purpose: ROM and RAM chip select decode from A19-A12
// Assumes: bounds are inclusive page numbers
// Notes: no strobe qualification, so selects may glitch
`timescale 1ns/1ps

module iog_csel (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [7:0] mem_page,
    input wire logic [7:0] ram_upper_bound,
    input wire logic [7:0] ram_lower_bound,
    input wire logic [7:0] rom_upper_bound,
    input wire logic rom_disable,
    output logic rom_select_n,
    output logic ram_select_n
);
    logic rom_hit;
    logic ram_hit;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    // purely combinational by design: address only, no strobes
    assign rom_hit = (mem_page <= rom_upper_bound);
    assign ram_hit = (mem_page <= ram_upper_bound) && (mem_page >= ram_lower_bound);
    assign rom_select_n = !(rom_hit && !rom_disable);
    assign ram_select_n = !ram_hit;

    a_rom_disabled: assert property (@(posedge core_clk) disable iff (!rstn)
        rom_disable |-> rom_select_n)
        else $error("rom select active while disabled");

    a_ram_window: assert property (@(posedge core_clk) disable iff (!rstn)
        !ram_select_n |-> (mem_page >= ram_lower_bound && mem_page <= ram_upper_bound))
        else $error("ram select outside its window");

    a_rom_bound: assert property (@(posedge core_clk) disable iff (!rstn)
        (!rom_disable && mem_page <= rom_upper_bound) |-> !rom_select_n)
        else $error("rom select missing below bound");

endmodule : iog_csel

// *** design/iog_top.sv ***
// Purpose: I/O page decode, parallel ports, chip selects, config and serial glue
// Assumes: core strobes io_rd and io_wr for one cycle with a stable request
// Notes: read data appear one cycle after io_rd
`timescale 1ns/1ps
`include "iog_cfg.svh"

// What this block does
// - two 8-bit ports with direction registers
// - config bit D0 gives counter pins priority
// - all port pins inputs after reset
// - ROM select active when page at or below bound, RAM select when within its bounds
// - bounds held at EAh, EBh, ECh
// - selects decoded from A19-A12 combinationally only
// - config bit D5 disables ROM select
// - emulator mode shows peripheral reads outside
// - otherwise data bus stays off during reads
// - full eight-bit decode, no aliases
// - fixed map of glue page registers
// - core registers in relocatable 64-byte block
// - two wait states on serial interrupt acknowledge
// - serial controller reset by reset, system clock
// - port one carries counter outputs and triggers
module iog_top (
    input wire logic core_clk,
    input wire logic rstn,
    input iog_pkg::iog_io_req_t io_req,
    output logic [7:0] io_rdata,
    output logic io_rvalid,
    input wire logic [1:0] core_reg_block,
    output logic tmr_sel,
    output logic [1:0] tmr_chan,
    input wire logic [7:0] tmr_rdata,
    output logic ser_sel,
    output logic ser_data_sel,
    input wire logic [7:0] ser_rdata,
    output logic [7:0] ext_data_out,
    output logic ext_data_oe,
    input wire logic [7:0] mem_page,
    output logic rom_select_n,
    output logic ram_select_n,
    input wire logic [7:0] port_one_in,
    output logic [7:0] port_one_out,
    output logic [7:0] port_one_oe,
    input wire logic [7:0] port_two_in,
    output logic [7:0] port_two_out,
    output logic [7:0] port_two_oe,
    input wire logic [3:0] zero_count_out,
    output logic [3:0] count_trigger_in,
    input wire logic intack_start,
    input wire logic ser_iack,
    output logic wait_n,
    output logic ser_reset_n,
    output logic ser_clk
);
    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    logic [7:0] ram_upper_bound;
    logic [7:0] ram_lower_bound;
    logic [7:0] rom_upper_bound;
    logic [7:0] system_config;
    logic [7:0] p1_dir;
    logic [7:0] p2_dir;
    logic [7:0] p1_rd;
    logic [7:0] p2_rd;
    logic [1:0] wait_cnt;
    iog_pkg::iog_pin_drv_t p1_drv;
    iog_pkg::iog_pin_drv_t p2_drv;

    wire [7:0] a = io_req.addr;
    wire page_hit = (a[7:4] == `IOG_PAGE_HI);
    wire core_hit = (a[7:6] == core_reg_block);
    wire timer_mode = system_config[`IOG_CFG_TMR_BIT];
    wire emu_mode = system_config[`IOG_CFG_EMU_BIT];
    wire rom_disable = system_config[`IOG_CFG_ROMDIS_BIT];

    wire sel_p1_dir = hit(a, `IOG_ADDR_P1_DIR);
    wire sel_p1_data = hit(a, `IOG_ADDR_P1_DATA);
    wire sel_p2_dir = hit(a, `IOG_ADDR_P2_DIR);
    wire sel_p2_data = hit(a, `IOG_ADDR_P2_DATA);
    wire sel_ram_ub = hit(a, `IOG_ADDR_RAM_UB);
    wire sel_ram_lb = hit(a, `IOG_ADDR_RAM_LB);
    wire sel_rom_ub = hit(a, `IOG_ADDR_ROM_UB);
    wire sel_cfg = hit(a, `IOG_ADDR_SYS_CFG);
    wire sel_ser_c = hit(a, `IOG_ADDR_SER_CTRL);
    wire sel_ser_d = hit(a, `IOG_ADDR_SER_DATA);
    wire sel_tmr = (a[7:2] == 6'((`IOG_ADDR_TMR_BASE) >> 2));

    // counter and serial units decode their own strobes from these
    assign tmr_sel = sel_tmr;
    assign tmr_chan = a[1:0];
    assign ser_sel = sel_ser_c || sel_ser_d;
    assign ser_data_sel = sel_ser_d;

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    // reserved addresses fall to zero in the default term
    wire [7:0] rd_mux =
        sel_p1_dir ? p1_dir :
        sel_p1_data ? p1_rd :
        sel_p2_dir ? p2_dir :
        sel_p2_data ? p2_rd :
        sel_tmr ? tmr_rdata :
        ser_sel ? ser_rdata :
        sel_ram_ub ? ram_upper_bound :
        sel_ram_lb ? ram_lower_bound :
        sel_rom_ub ? rom_upper_bound :
        sel_cfg ? system_config : 8'h00;

    // core registers stay hidden even if software overlaps the block
    wire show_ext = io_req.rd && page_hit && emu_mode && !core_hit;

    // ----------------------------------------
    // glue registers
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ram_upper_bound <= `IOG_RST_RAM_UB;
            ram_lower_bound <= `IOG_RST_RAM_LB;
            rom_upper_bound <= `IOG_RST_ROM_UB;
            system_config <= `IOG_RST_CFG;
        end else if (io_req.wr) begin
            if (sel_ram_ub) ram_upper_bound <= io_req.wdata;
            if (sel_ram_lb) ram_lower_bound <= io_req.wdata;
            if (sel_rom_ub) rom_upper_bound <= io_req.wdata;
            if (sel_cfg) system_config <= io_req.wdata;
        end
    end

    // ----------------------------------------
    // read answer and emulator visibility
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            io_rdata <= 8'h00;
            io_rvalid <= 1'b0;
            ext_data_out <= 8'h00;
            ext_data_oe <= 1'b0;
        end else begin
            io_rvalid <= io_req.rd && page_hit;
            if (io_req.rd && page_hit) io_rdata <= rd_mux;
            ext_data_oe <= show_ext;
            if (show_ext) ext_data_out <= rd_mux;
        end
    end

    // ----------------------------------------
    // parallel ports
    // ----------------------------------------
    iog_port u_port_one (
        .core_clk(core_clk),
        .rstn(rstn),
        .wr_dir(io_req.wr && sel_p1_dir),
        .wr_data(io_req.wr && sel_p1_data),
        .wdata(io_req.wdata),
        .pin_in(port_one_in),
        .dir(p1_dir),
        .data_rd(p1_rd),
        .drv(p1_drv)
    );

    iog_port u_port_two (
        .core_clk(core_clk),
        .rstn(rstn),
        .wr_dir(io_req.wr && sel_p2_dir),
        .wr_data(io_req.wr && sel_p2_data),
        .wdata(io_req.wdata),
        .pin_in(port_two_in),
        .dir(p2_dir),
        .data_rd(p2_rd),
        .drv(p2_drv)
    );

    // counter mode overrides the port one register settings
    assign port_one_out = timer_mode ? {zero_count_out, 4'h0} : p1_drv.out;
    assign port_one_oe = timer_mode ? 8'hF0 : p1_drv.oe;
    assign count_trigger_in = timer_mode ? port_one_in[3:0] : 4'h0;
    assign port_two_out = p2_drv.out;
    assign port_two_oe = p2_drv.oe;

    // ----------------------------------------
    // chip selects
    // ----------------------------------------
    iog_csel u_csel (
        .core_clk(core_clk),
        .rstn(rstn),
        .mem_page(mem_page),
        .ram_upper_bound(ram_upper_bound),
        .ram_lower_bound(ram_lower_bound),
        .rom_upper_bound(rom_upper_bound),
        .rom_disable(rom_disable),
        .rom_select_n(rom_select_n),
        .ram_select_n(ram_select_n)
    );

    // ----------------------------------------
    // serial controller glue
    // ----------------------------------------
    // vectored acknowledge is slow inside the serial unit, hence the stall
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wait_cnt <= 2'h0;
        end else if (intack_start && ser_iack) begin
            wait_cnt <= `IOG_SER_WAIT_STATES;
        end else if (wait_cnt != 2'h0) begin
            wait_cnt <= wait_cnt - 2'h1;
        end
    end

    assign wait_n = (wait_cnt == 2'h0);
    assign ser_reset_n = rstn;
    assign ser_clk = core_clk;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_iack;
        intack_start && ser_iack;
    endsequence

    sequence s_two_waits;
        !wait_n [*2] ##1 wait_n;
    endsequence

    a_wait_two_states: assert property (@(posedge core_clk) disable iff (!rstn)
        s_iack |=> s_two_waits)
        else $error("serial acknowledge did not get two wait states");

    a_inputs_reset: assert property (@(posedge core_clk)
        $rose(rstn) |-> (port_one_oe == 8'h00 && port_two_oe == 8'h00))
        else $error("port pins not inputs after reset");

    a_timer_priority: assert property (@(posedge core_clk) disable iff (!rstn)
        timer_mode |-> (port_one_oe == 8'hF0 && port_one_out[7:4] == zero_count_out))
        else $error("counter outputs not on port one");

    a_trigger_route: assert property (@(posedge core_clk) disable iff (!rstn)
        timer_mode |-> count_trigger_in == port_one_in[3:0])
        else $error("counter triggers not taken from port one");

    a_emu_visible: assert property (@(posedge core_clk) disable iff (!rstn)
        (io_req.rd && page_hit && emu_mode && !core_hit) |=> (ext_data_oe && ext_data_out == io_rdata))
        else $error("emulator read not driven outside");

    a_hidden_reads: assert property (@(posedge core_clk) disable iff (!rstn)
        (io_req.rd && !emu_mode) |=> !ext_data_oe)
        else $error("internal read visible outside");

    a_core_excluded: assert property (@(posedge core_clk) disable iff (!rstn)
        (io_req.rd && core_hit) |=> !ext_data_oe)
        else $error("core register read driven outside");

    a_reserved_zero: assert property (@(posedge core_clk) disable iff (!rstn)
        (io_req.rd && (a == `IOG_ADDR_RSVD0 || a == `IOG_ADDR_RSVD1)) |=> (io_rvalid && io_rdata == 8'h00))
        else $error("reserved address read not zero");

    a_bound_write: assert property (@(posedge core_clk) disable iff (!rstn)
        (io_req.wr && sel_rom_ub) |=> rom_upper_bound == $past(io_req.wdata))
        else $error("rom bound write lost");

    a_timer_decode: assert property (@(posedge core_clk) disable iff (!rstn)
        tmr_sel |-> (a >= `IOG_ADDR_TMR_BASE && a < `IOG_ADDR_SER_CTRL))
        else $error("counter select aliased");

endmodule : iog_top

// *** test/iog_periph_model.sv ***
// Purpose: far side of the glue block: counter and serial read data, port pins
// Assumes: pins pulled to ext levels where the block does not drive
// Notes: unselected read data changes every cycle
`timescale 1ns/1ps

module iog_periph_model (
    input wire logic core_clk,
    input wire logic tmr_sel,
    input wire logic [1:0] tmr_chan,
    input wire logic ser_sel,
    input wire logic ser_data_sel,
    input wire logic [7:0] ext_one,
    input wire logic [7:0] ext_two,
    input wire logic [7:0] port_one_out,
    input wire logic [7:0] port_one_oe,
    input wire logic [7:0] port_two_out,
    input wire logic [7:0] port_two_oe,
    output logic [7:0] tmr_rdata,
    output logic [7:0] ser_rdata,
    output logic [7:0] port_one_in,
    output logic [7:0] port_two_in
);
    // ----------------------------------------
    // read data
    // ----------------------------------------
    // idle value moves each cycle so a stale sample cannot pass
    logic [7:0] idle_pat = 8'h00;
    always_ff @(posedge core_clk) begin
        idle_pat <= idle_pat + 8'h01;
    end
    assign tmr_rdata = tmr_sel ? {6'h30, tmr_chan} : idle_pat;
    assign ser_rdata = ser_sel ? (ser_data_sel ? 8'h96 : 8'h69) : ~idle_pat;
    // ----------------------------------------
    // pin levels
    // ----------------------------------------
    assign port_one_in = (port_one_out & port_one_oe) | (ext_one & ~port_one_oe);
    assign port_two_in = (port_two_out & port_two_oe) | (ext_two & ~port_two_oe);
endmodule : iog_periph_model

// *** test/tb.sv ***
// Purpose: register, select, port, emulator and wait checks of the glue block
// Assumes: requests driven at the falling edge, read answer one cycle later
// Notes: no random stimulus
`timescale 1ns/1ps
`include "iog_cfg.svh"

module tb;
    logic core_clk;
    logic rstn;
    iog_pkg::iog_io_req_t io_req;
    logic [7:0] io_rdata, tmr_rdata, ser_rdata, ext_data_out, mem_page;
    logic [7:0] port_one_in, port_one_out, port_one_oe, port_two_in, port_two_out, port_two_oe;
    logic [1:0] core_reg_block, tmr_chan;
    logic [3:0] zero_count_out, count_trigger_in;
    logic io_rvalid, tmr_sel, ser_sel, ser_data_sel, ext_data_oe, rom_select_n, ram_select_n;
    logic intack_start, ser_iack, wait_n, ser_reset_n, ser_clk;
    logic [7:0] u_pages_a [4] = '{8'h00, 8'h7F, 8'h80, 8'hFF};
    logic [7:0] u_pages_b [4] = '{8'h3F, 8'h40, 8'hC0, 8'hC1};
    logic [7:0] ext_one, ext_two, rub, rlb, rob, rd_ext;
    logic rdis, rd_oe;
    int miscompares;
    int checks;

    iog_top u_dut (.core_clk(core_clk), .rstn(rstn), .io_req(io_req), .io_rdata(io_rdata),
        .io_rvalid(io_rvalid), .core_reg_block(core_reg_block), .tmr_sel(tmr_sel), .tmr_chan(tmr_chan),
        .tmr_rdata(tmr_rdata), .ser_sel(ser_sel), .ser_data_sel(ser_data_sel), .ser_rdata(ser_rdata),
        .ext_data_out(ext_data_out), .ext_data_oe(ext_data_oe), .mem_page(mem_page),
        .rom_select_n(rom_select_n), .ram_select_n(ram_select_n), .port_one_in(port_one_in),
        .port_one_out(port_one_out), .port_one_oe(port_one_oe), .port_two_in(port_two_in),
        .port_two_out(port_two_out), .port_two_oe(port_two_oe), .zero_count_out(zero_count_out),
        .count_trigger_in(count_trigger_in), .intack_start(intack_start), .ser_iack(ser_iack),
        .wait_n(wait_n), .ser_reset_n(ser_reset_n), .ser_clk(ser_clk));

    iog_periph_model u_far (.core_clk(core_clk), .tmr_sel(tmr_sel), .tmr_chan(tmr_chan), .ser_sel(ser_sel),
        .ser_data_sel(ser_data_sel), .ext_one(ext_one), .ext_two(ext_two), .port_one_out(port_one_out),
        .port_one_oe(port_one_oe), .port_two_out(port_two_out), .port_two_oe(port_two_oe),
        .tmr_rdata(tmr_rdata), .ser_rdata(ser_rdata), .port_one_in(port_one_in), .port_two_in(port_two_in));

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic report_and_stop;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic io_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        io_req.addr = a;
        io_req.wdata = d;
        io_req.wr = 1'b1;
        @(negedge core_clk);
        io_req.wr = 1'b0;
    endtask : io_wr

    // answer is looked at in the one cycle that it stands
    task automatic io_rd(input logic [7:0] a, input logic vld, input logic [7:0] exp);
        @(negedge core_clk);
        io_req.addr = a;
        io_req.rd = 1'b1;
        @(negedge core_clk);
        io_req.rd = 1'b0;
        rd_oe = ext_data_oe;
        rd_ext = ext_data_out;
        chk("io_rvalid", {7'h00, vld}, {7'h00, io_rvalid});
        if (vld) begin
            chk("io_rdata", exp, io_rdata);
        end
    endtask : io_rd

    task automatic sel_chk(input logic [7:0] pg);
        @(negedge core_clk);
        mem_page = pg;
        #1;
        chk("rom_select_n", {7'h00, !(pg <= rob && !rdis)}, {7'h00, rom_select_n});
        chk("ram_select_n", {7'h00, !(pg >= rlb && pg <= rub)}, {7'h00, ram_select_n});
    endtask : sel_chk

    // ----------------------------------------
    // clock, watchdog
    // ----------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    initial begin
        #100000;
        miscompares++;
        report_and_stop();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        io_req = '0;
        rstn = 1'b0;
        core_reg_block = 2'h0;
        mem_page = 8'h00;
        zero_count_out = 4'hA;
        intack_start = 1'b0;
        ser_iack = 1'b0;
        ext_one = 8'h3C;
        ext_two = 8'hC3;
        rub = `IOG_RST_RAM_UB;
        rlb = `IOG_RST_RAM_LB;
        rob = `IOG_RST_ROM_UB;
        rdis = 1'b0;
        repeat (3) @(negedge core_clk);
        chk("ser_reset_n", 8'h00, {7'h00, ser_reset_n});
        chk("port_one_oe", 8'h00, port_one_oe);
        repeat (3) @(negedge core_clk);
        rstn = 1'b1;
        @(negedge core_clk);
        chk("ser_reset_n", 8'h01, {7'h00, ser_reset_n});
        chk("port_two_oe", 8'h00, port_two_oe);
        #7;
        chk("ser_clk", 8'h01, {7'h00, ser_clk});
        io_rd(`IOG_ADDR_P1_DIR, 1'b1, `IOG_RST_DIR);
        io_rd(`IOG_ADDR_P2_DIR, 1'b1, `IOG_RST_DIR);
        io_rd(`IOG_ADDR_P1_DATA, 1'b1, ext_one);
        io_rd(`IOG_ADDR_RAM_UB, 1'b1, `IOG_RST_RAM_UB);
        io_rd(`IOG_ADDR_RAM_LB, 1'b1, `IOG_RST_RAM_LB);
        io_rd(`IOG_ADDR_ROM_UB, 1'b1, `IOG_RST_ROM_UB);
        io_rd(`IOG_ADDR_SYS_CFG, 1'b1, `IOG_RST_CFG);
        foreach (u_pages_a[i]) sel_chk(u_pages_a[i]);
        io_wr(`IOG_ADDR_RAM_UB, 8'hC0);
        io_wr(`IOG_ADDR_RAM_LB, 8'h40);
        io_wr(`IOG_ADDR_ROM_UB, 8'h3F);
        rub = 8'hC0;
        rlb = 8'h40;
        rob = 8'h3F;
        foreach (u_pages_b[i]) sel_chk(u_pages_b[i]);
        io_wr(`IOG_ADDR_SYS_CFG, 8'h20);
        rdis = 1'b1;
        sel_chk(8'h00);
        io_wr(`IOG_ADDR_RSVD0, 8'h5A);
        io_rd(`IOG_ADDR_RSVD0, 1'b1, 8'h00);
        io_rd(`IOG_ADDR_RSVD1, 1'b1, 8'h00);
        io_wr(8'h6A, 8'h11);
        io_rd(8'h6A, 1'b0, 8'h00);
        io_rd(`IOG_ADDR_RAM_UB, 1'b1, 8'hC0);
        io_wr(`IOG_ADDR_P1_DIR, 8'h0F);
        io_wr(`IOG_ADDR_P1_DATA, 8'hA5);
        io_wr(`IOG_ADDR_P2_DIR, 8'hF0);
        io_wr(`IOG_ADDR_P2_DATA, 8'h5A);
        chk("port_one_oe", 8'h0F, port_one_oe);
        chk("port_one_out", 8'hA5, port_one_out);
        chk("port_two_oe", 8'hF0, port_two_oe);
        chk("port_two_out", 8'h5A, port_two_out);
        io_rd(`IOG_ADDR_P1_DATA, 1'b1, 8'h35);
        io_rd(`IOG_ADDR_P2_DATA, 1'b1, 8'h53);
        io_wr(`IOG_ADDR_SYS_CFG, 8'h21);
        chk("port_one_oe", 8'hF0, port_one_oe);
        chk("port_one_out", 8'hA0, port_one_out);
        chk("count_trigger_in", 8'h0C, {4'h0, count_trigger_in});
        io_wr(`IOG_ADDR_SYS_CFG, 8'h22);
        chk("count_trigger_in", 8'h00, {4'h0, count_trigger_in});
        chk("port_one_oe", 8'h0F, port_one_oe);
        for (int ch = 0; ch < 4; ch++) begin
            io_rd(`IOG_ADDR_TMR_BASE + 8'(ch), 1'b1, 8'hC0 | 8'(ch));
            chk("ext_data_oe", 8'h01, {7'h00, rd_oe});
            chk("ext_data_out", 8'hC0 | 8'(ch), rd_ext);
        end
        io_rd(`IOG_ADDR_SER_CTRL, 1'b1, 8'h69);
        io_rd(`IOG_ADDR_SER_DATA, 1'b1, 8'h96);
        core_reg_block = 2'h1;
        io_rd(`IOG_ADDR_SYS_CFG, 1'b1, 8'h22);
        chk("ext_data_oe", 8'h01, {7'h00, rd_oe});
        io_rd(8'h45, 1'b0, 8'h00);
        chk("ext_data_oe", 8'h00, {7'h00, rd_oe});
        io_wr(`IOG_ADDR_SYS_CFG, 8'h20);
        io_rd(`IOG_ADDR_ROM_UB, 1'b1, 8'h3F);
        chk("ext_data_oe", 8'h00, {7'h00, rd_oe});
        @(negedge core_clk);
        intack_start = 1'b1;
        @(negedge core_clk);
        intack_start = 1'b0;
        chk("wait_n", 8'h01, {7'h00, wait_n});
        ser_iack = 1'b1;
        intack_start = 1'b1;
        @(negedge core_clk);
        intack_start = 1'b0;
        chk("wait_n", 8'h00, {7'h00, wait_n});
        @(negedge core_clk);
        chk("wait_n", 8'h00, {7'h00, wait_n});
        @(negedge core_clk);
        chk("wait_n", 8'h01, {7'h00, wait_n});
        report_and_stop();
    end

endmodule : tb
